// [rrm_map.svh]
// Constants of the redundancy message handler: framing bytes, codes,
// register offsets, reset values and interrupt bit positions.
// Assumes nothing; included by bare name wherever needed.
`ifndef RRM_MAP_SVH
`define RRM_MAP_SVH
`define RRM_STX       8'h02
`define RRM_ETX       8'h03
`define RRM_INS_SREQ  8'h45
`define RRM_INS_SREP  8'h46
`define RRM_INS_CHG   8'h47
`define RRM_LEN_SREQ  4'h6
`define RRM_LEN_REP   8'h0D
`define RRM_LEN_CHG   4'h9
`define RRM_LEN_MIN   8'h06
`define RRM_LEN_MAX   8'h09
`define RRM_LAST_IDX  4'hC
`define RRM_OFS_ADDR  4'h0
`define RRM_OFS_STAT  4'h4
`define RRM_OFS_MASK  4'h8
`define RRM_OFS_INFO  4'hC
`define RRM_RST_ADDR  8'h01
`define RRM_IRQ_REP   0
`define RRM_IRQ_CHG   1
`define RRM_IRQ_DROP  2
`endif

// [rrm_pkg.sv]
// Types shared by the redundancy message handler modules.
// Assumes rrm_map.svh for the numeric constants.
package rrm_pkg;
  typedef logic [6:0][7:0] rrm_rep_t;
  typedef logic [2:0][7:0] rrm_fld_t;
  typedef enum logic {RX_IDLE, RX_BODY} rrm_rx_st_t;
  typedef struct packed {
    rrm_rx_st_t st;
    logic [3:0] idx;
    logic [3:0] len;
    logic [7:0] addr;
    logic [7:0] ins;
    rrm_fld_t   fld;
    logic [7:0] sum;
    logic       sum_ok;
    logic       frm_valid;
    logic       frm_drop;
  } rrm_rx_state_t;
  typedef struct packed {
    logic       busy;
    logic       done;
    logic [3:0] idx;
    logic [7:0] addr;
    rrm_rep_t   rep;
    logic [7:0] sum;
    logic [7:0] cur;
  } rrm_tx_state_t;
endpackage

// [rrm_if.sv]
// Carrier between the handler top, its frame receiver and its reply sender.
// Assumes all three parties share one clock.
`timescale 1ns/10ps
`default_nettype none
interface rrm_if;
  logic [7:0]        own_addr;
  logic              frm_valid;
  logic              frm_drop;
  logic [7:0]        ins;
  rrm_pkg::rrm_fld_t fld;
  logic              tx_start;
  rrm_pkg::rrm_rep_t rep;
  logic              tx_busy;
  logic              tx_done;
  modport rx (input own_addr, output frm_valid, frm_drop, ins, fld);
  modport tx (input own_addr, tx_start, rep, output tx_busy, tx_done);
  modport top (output own_addr, tx_start, rep,
               input frm_valid, frm_drop, ins, fld, tx_busy, tx_done);
endinterface
`default_nettype wire

// [rrm_rx.sv]
// Frame receiver: checks start, length, address, checksum and end byte.
// Assumes one byte per rx_valid cycle, synchronous to the clock.
`timescale 1ns/10ps
`default_nettype none
`include "rrm_map.svh"
module rrm_rx (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] rx_data,
  input  wire logic       rx_valid,
  rrm_if.rx               bus
);
  rrm_pkg::rrm_rx_state_t s_reg;
  rrm_pkg::rrm_rx_state_t s_next;

  // Walks the frame byte by byte; a bad frame is dropped without reply.
  always_comb
  begin
    s_next = s_reg;
    s_next.frm_valid = 1'b0;
    s_next.frm_drop = 1'b0;
    if (rx_valid)
    begin
      unique case (s_reg.st)
        rrm_pkg::RX_IDLE:
          if (rx_data == `RRM_STX)
          begin
            s_next.st = rrm_pkg::RX_BODY;
            s_next.idx = 4'h2;
            s_next.sum = 8'h00;
          end
        rrm_pkg::RX_BODY:
        begin
          s_next.idx = s_reg.idx + 4'h1;
          if (s_reg.idx == 4'h2)
          begin
            s_next.len = rx_data[3:0];
            s_next.sum = rx_data;
            if (rx_data < `RRM_LEN_MIN || rx_data > `RRM_LEN_MAX)
            begin
              s_next.st = rrm_pkg::RX_IDLE;
              s_next.frm_drop = 1'b1;
            end
          end
          else if (s_reg.idx == 4'h3)
          begin
            s_next.addr = rx_data;
            s_next.sum = s_reg.sum + rx_data;
          end
          else if (s_reg.idx == 4'h4)
          begin
            s_next.ins = rx_data;
            s_next.sum = s_reg.sum + rx_data;
          end
          else if (s_reg.idx == s_reg.len - 4'h1)
            s_next.sum_ok = (rx_data == s_reg.sum);
          else if (s_reg.idx == s_reg.len)
          begin
            s_next.st = rrm_pkg::RX_IDLE;
            if (rx_data == `RRM_ETX && s_reg.sum_ok
                && s_reg.addr == bus.own_addr
                && ((s_reg.ins == `RRM_INS_SREQ
                     && s_reg.len == `RRM_LEN_SREQ)
                    || (s_reg.ins == `RRM_INS_CHG
                        && s_reg.len == `RRM_LEN_CHG)))
              s_next.frm_valid = 1'b1;
            else
              s_next.frm_drop = 1'b1;
          end
          else
          begin
            s_next.fld[s_reg.idx[1:0] - 2'h1] = rx_data; // Bytes 5 to 7.
            s_next.sum = s_reg.sum + rx_data;
          end
        end
      endcase
    end
  end

  // State register.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  // Decoded frame toward the top.
  assign bus.frm_valid = s_reg.frm_valid;
  assign bus.frm_drop  = s_reg.frm_drop;
  assign bus.ins       = s_reg.ins;
  assign bus.fld       = s_reg.fld;

  AST_NO_BOTH: assert property (@(posedge clk) disable iff (!rst_n)
    !(s_reg.frm_valid && s_reg.frm_drop))
    else $error("Frame both accepted and dropped.");
endmodule
`default_nettype wire

// [rrm_tx.sv]
// Reply sender: emits the 13-byte redundancy status reply with no gaps.
// Assumes the sink takes a byte whenever tx_valid and tx_ready are high.
`timescale 1ns/10ps
`default_nettype none
`include "rrm_map.svh"
module rrm_tx (
  input  wire logic       clk,
  input  wire logic       rst_n,
  output logic      [7:0] tx_data,
  output logic            tx_valid,
  input  wire logic       tx_ready,
  rrm_if.tx               bus
);
  rrm_pkg::rrm_tx_state_t s_reg;
  rrm_pkg::rrm_tx_state_t s_next;

  // Sum of every byte between start byte and checksum.
  function automatic logic [7:0] csum(input logic [7:0] a,
                                      input rrm_pkg::rrm_rep_t r);
    logic [7:0] t;
    t = `RRM_LEN_REP + a + `RRM_INS_SREP;
    for (int i = 0; i < 7; i++)
      t = t + r[i];
    return t;
  endfunction

  // Byte at 0-based position i of the reply.
  function automatic logic [7:0] pick(input rrm_pkg::rrm_tx_state_t s,
                                      input logic [3:0] i);
    logic [3:0] k;
    k = i - 4'h4;
    if (i == 4'h1)
      return `RRM_LEN_REP;
    if (i == 4'h2)
      return s.addr;
    if (i == 4'h3)
      return `RRM_INS_SREP;
    if (i < 4'hB)
      return s.rep[k[2:0]];
    if (i == 4'hB)
      return s.sum;
    return `RRM_ETX;
  endfunction

  // Loads a reply, then steps one byte per accepted handshake.
  always_comb
  begin
    s_next = s_reg;
    s_next.done = 1'b0;
    if (!s_reg.busy && bus.tx_start)
    begin
      s_next.busy = 1'b1;
      s_next.idx = 4'h0;
      s_next.addr = bus.own_addr;
      s_next.rep = bus.rep;
      s_next.sum = csum(bus.own_addr, bus.rep);
      s_next.cur = `RRM_STX;
    end
    else if (s_reg.busy && tx_ready)
    begin
      if (s_reg.idx == `RRM_LAST_IDX)
      begin
        s_next.busy = 1'b0;
        s_next.done = 1'b1;
      end
      else
      begin
        s_next.idx = s_reg.idx + 4'h1;
        s_next.cur = pick(s_reg, s_reg.idx + 4'h1);
      end
    end
  end

  // State register.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign tx_data = s_reg.cur;
  assign tx_valid = s_reg.busy;
  assign bus.tx_busy = s_reg.busy;
  assign bus.tx_done = s_reg.done;

  AST_REP_STX: assert property (@(posedge clk) disable iff (!rst_n)
    (tx_valid && s_reg.idx == 4'h0) |-> tx_data == 8'h02)
    else $error("Reply does not open with the start byte.");
  AST_REP_INS: assert property (@(posedge clk) disable iff (!rst_n)
    (tx_valid && s_reg.idx == 4'h3) |-> tx_data == 8'h46)
    else $error("Reply instruction byte wrong.");
  AST_REP_ETX: assert property (@(posedge clk) disable iff (!rst_n)
    (tx_valid && s_reg.idx == 4'hC) |-> tx_data == 8'h03)
    else $error("Reply does not close with the end byte.");
  AST_NO_GAP: assert property (@(posedge clk) disable iff (!rst_n)
    (tx_valid && !tx_ready) |=> tx_valid && $stable(tx_data))
    else $error("Reply byte dropped or changed while stalled.");
  CVR_REPLY: cover property (@(posedge clk) disable iff (!rst_n)
    s_reg.done);
endmodule
`default_nettype wire

// [rrm_top.sv]
// Redundancy message handler top: register port, request decoding,
// change-request filtering and status reply building.
// Assumes byte streams and inputs synchronous to sys_clk.
`timescale 1ns/10ps
`default_nettype none
`include "rrm_map.svh"
module rrm_top (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic  [3:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  output logic             irq,
  input  wire logic  [7:0] rx_data,
  input  wire logic        rx_valid,
  output logic       [7:0] tx_data,
  output logic             tx_valid,
  input  wire logic        tx_ready,
  input  wire logic  [1:0] red_cfg,
  input  wire logic        red_auto,
  input  wire logic  [1:0] unit_id,
  input  wire logic        unit_online,
  input  wire logic  [3:0] unit_prio,
  input  wire logic        ctrl_present,
  input  wire logic  [1:0] online_unit,
  input  wire logic        coax_pos,
  output logic             chg_mode_stb,
  output logic             chg_mode_auto,
  output logic             chg_online_stb,
  output logic       [1:0] chg_online_unit,
  output logic             chg_prio_stb,
  output logic       [3:0] chg_prio
);
  typedef struct packed {
    logic [31:0]       rdata;
    logic [7:0]        own_addr;
    logic [2:0]        stat;
    logic [2:0]        mask;
    logic              tx_start;
    rrm_pkg::rrm_rep_t rep;
    logic              mode_stb;
    logic              mode_auto;
    logic              onl_stb;
    logic [1:0]        onl_unit;
    logic              pri_stb;
    logic [3:0]        pri;
  } rrm_top_state_t;

  rrm_top_state_t s_reg;
  rrm_top_state_t s_next;
  logic [1:0]     rst_sync_reg;
  logic           rst_s_n;
  rrm_if          bus ();

  // Reset is released through two flip-flops.
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      rst_sync_reg <= 2'b00;
    else
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
  assign rst_s_n = rst_sync_reg[1];

  // Letter for a unit code: 0 is A, 1 is B, 2 is S.
  function automatic logic [7:0] unit_chr(input logic [1:0] u);
    unique case (u)
      2'h0: return 8'h41;
      2'h1: return 8'h42;
      default: return 8'h53;
    endcase
  endfunction

  // Unit code for a letter; 2'h3 marks a letter that names no unit.
  function automatic logic [1:0] chr_unit(input logic [7:0] c);
    unique case (c)
      8'h41: return 2'h0;
      8'h42: return 2'h1;
      8'h53: return 2'h2;
      default: return 2'h3;
    endcase
  endfunction

  // Reply fields, bytes 5 to 11, from the unit's present state.
  function automatic rrm_pkg::rrm_rep_t build_rep();
    rrm_pkg::rrm_rep_t r;
    r[0] = (red_cfg == 2'h0) ? 8'h31 : (red_cfg == 2'h1) ? 8'h32 : 8'h4E;
    r[1] = (red_cfg == 2'h0) ? 8'h58 : red_auto ? 8'h41 : 8'h4D;
    r[2] = unit_online ? 8'h31 : 8'h30;
    r[3] = unit_chr(unit_id);
    r[4] = (red_cfg == 2'h0 || unit_id == 2'h2) ? 8'h58
           : {4'h3, unit_prio};
    if (!ctrl_present)
      r[5] = 8'h40;
    else if (red_cfg == 2'h0 || (red_cfg == 2'h1 && unit_id == 2'h2))
      r[5] = unit_chr(online_unit);
    else
      r[5] = 8'h58;
    r[6] = !ctrl_present ? 8'h40 : coax_pos ? 8'h32 : 8'h31;
    return r;
  endfunction

  logic [7:0] f_mode;
  logic [7:0] f_onl;
  logic [7:0] f_pri;
  logic       is_chg;
  logic       ok_mode;
  logic       ok_onl;
  logic       ok_p12;
  logic       ok_pn;
  logic [2:0] ev;
  logic [2:0] clr;

  // Field checks on a received change request.
  always_comb
  begin
    f_mode = bus.fld[0];
    f_onl = bus.fld[1];
    f_pri = bus.fld[2];
    is_chg = bus.frm_valid && bus.ins == `RRM_INS_CHG;
    ok_mode = f_mode == 8'h4D || f_mode == 8'h41;
    ok_onl = chr_unit(f_onl) < 2'h2
             || (chr_unit(f_onl) == 2'h2 && red_cfg == 2'h1);
    ok_p12 = f_pri == 8'h31 || f_pri == 8'h32;
    ok_pn = f_pri >= 8'h31 && f_pri <= 8'h38;
  end

  // Registers, change filtering and reply launch.
  always_comb
  begin
    s_next = s_reg;
    s_next.rdata = 32'h0000_0000;
    s_next.tx_start = 1'b0;
    s_next.mode_stb = 1'b0;
    s_next.onl_stb = 1'b0;
    s_next.pri_stb = 1'b0;
    if (bus.frm_valid && bus.ins == `RRM_INS_SREQ && !bus.tx_busy)
    begin
      s_next.tx_start = 1'b1;
      s_next.rep = build_rep();
    end
    if (is_chg)
    begin
      s_next.mode_auto = (f_mode == 8'h41);
      s_next.onl_unit = chr_unit(f_onl);
      s_next.pri = f_pri[3:0];
      unique case (red_cfg)
        2'h0: s_next.onl_stb = ok_onl;
        2'h1:
          if (unit_id == 2'h2)
          begin
            s_next.mode_stb = ok_mode;
            s_next.onl_stb = ok_onl;
          end
          else
            s_next.pri_stb = ok_p12;
        default:
        begin
          s_next.mode_stb = ok_mode;
          s_next.pri_stb = ok_pn;
        end
      endcase
    end
    ev = 3'h0;
    ev[`RRM_IRQ_REP] = bus.tx_done;
    ev[`RRM_IRQ_CHG] = s_reg.mode_stb || s_reg.onl_stb || s_reg.pri_stb;
    ev[`RRM_IRQ_DROP] = bus.frm_drop
                        || (bus.frm_valid && bus.ins == `RRM_INS_SREQ
                            && bus.tx_busy);
    clr = (reg_wr && reg_addr == `RRM_OFS_STAT) ? reg_wdata[2:0] : 3'h0;
    s_next.stat = (s_reg.stat & ~clr) | ev; // Set wins over clear.
    if (reg_wr && reg_addr == `RRM_OFS_ADDR)
      s_next.own_addr = reg_wdata[7:0];
    if (reg_wr && reg_addr == `RRM_OFS_MASK)
      s_next.mask = reg_wdata[2:0];
    if (reg_rd)
    begin
      unique case (reg_addr)
        `RRM_OFS_ADDR: s_next.rdata = {24'h0, s_reg.own_addr};
        `RRM_OFS_STAT: s_next.rdata = {29'h0, s_reg.stat};
        `RRM_OFS_MASK: s_next.rdata = {29'h0, s_reg.mask};
        `RRM_OFS_INFO: s_next.rdata = {23'h0, bus.tx_busy, s_reg.pri,
                                       1'b0, s_reg.onl_unit,
                                       s_reg.mode_auto};
        default: s_next.rdata = 32'h0000_0000;
      endcase
    end
  end

  // State register.
  always_ff @(posedge sys_clk or negedge rst_s_n)
  begin
    if (!rst_s_n)
    begin
      s_reg <= '0;
      s_reg.own_addr <= `RRM_RST_ADDR;
    end
    else
      s_reg <= s_next;
  end

  assign reg_rdata = s_reg.rdata;
  assign irq = |(s_reg.stat & s_reg.mask);
  assign bus.own_addr = s_reg.own_addr;
  assign bus.tx_start = s_reg.tx_start;
  assign bus.rep = s_reg.rep;
  assign chg_mode_stb = s_reg.mode_stb;
  assign chg_mode_auto = s_reg.mode_auto;
  assign chg_online_stb = s_reg.onl_stb;
  assign chg_online_unit = s_reg.onl_unit;
  assign chg_prio_stb = s_reg.pri_stb;
  assign chg_prio = s_reg.pri;

  // Frame receiver.
  rrm_rx u_rx (
    .clk      (sys_clk),
    .rst_n    (rst_s_n),
    .rx_data  (rx_data),
    .rx_valid (rx_valid),
    .bus      (bus)
  );

  // Reply sender.
  rrm_tx u_tx (
    .clk      (sys_clk),
    .rst_n    (rst_s_n),
    .tx_data  (tx_data),
    .tx_valid (tx_valid),
    .tx_ready (tx_ready),
    .bus      (bus)
  );

  // Reply fields and change filtering, checked against the unit's inputs.
  AST_CFG_BYTE: assert property (@(posedge sys_clk)
    disable iff (!rst_s_n)
    (bus.frm_valid && bus.ins == 8'h45 && !bus.tx_busy && red_cfg == 2'h1)
    |=> s_reg.tx_start && s_reg.rep[0] == 8'h32)
    else $error("Configuration byte wrong for one-for-two.");
  AST_MODE_X: assert property (@(posedge sys_clk) disable iff (!rst_s_n)
    (bus.frm_valid && bus.ins == 8'h45 && red_cfg == 2'h0 && !bus.tx_busy)
    |=> s_reg.rep[1] == 8'h58)
    else $error("Mode byte not X in one-for-one.");
  AST_ONLINE: assert property (@(posedge sys_clk) disable iff (!rst_s_n)
    (bus.frm_valid && bus.ins == 8'h45 && unit_online && !bus.tx_busy)
    |=> s_reg.rep[2] == 8'h31)
    else $error("Online byte wrong.");
  AST_NO_CTRL: assert property (@(posedge sys_clk) disable iff (!rst_s_n)
    (bus.frm_valid && bus.ins == 8'h45 && !ctrl_present && !bus.tx_busy)
    |=> s_reg.rep[5] == 8'h40 && s_reg.rep[6] == 8'h40)
    else $error("Missing controller not shown as at-sign.");
  AST_ONE_ONE: assert property (@(posedge sys_clk)
    disable iff (!rst_s_n)
    (is_chg && red_cfg == 2'h0) |=> !chg_mode_stb && !chg_prio_stb)
    else $error("One-for-one accepted a field other than online unit.");
  AST_STBY: assert property (@(posedge sys_clk) disable iff (!rst_s_n)
    (is_chg && red_cfg == 2'h1 && unit_id == 2'h2) |=> !chg_prio_stb)
    else $error("Standby unit accepted a priority change.");
  AST_AB_PRIO: assert property (@(posedge sys_clk)
    disable iff (!rst_s_n)
    (is_chg && red_cfg == 2'h1 && unit_id != 2'h2)
    |=> !chg_mode_stb && !chg_online_stb)
    else $error("A or B unit accepted mode or online change.");
  AST_BAD_PRIO: assert property (@(posedge sys_clk)
    disable iff (!rst_s_n)
    (is_chg && red_cfg == 2'h1 && f_pri == 8'h33) |=> !chg_prio_stb)
    else $error("Priority outside one-for-two set accepted.");
  AST_DROP: assert property (@(posedge sys_clk) disable iff (!rst_s_n)
    bus.frm_drop |=> !s_reg.tx_start)
    else $error("Dropped frame started a reply.");
  AST_ONL_NAME: assert property (@(posedge sys_clk)
    disable iff (!rst_s_n)
    (bus.frm_valid && bus.ins == 8'h45 && !bus.tx_busy && ctrl_present
     && red_cfg == 2'h1 && unit_id == 2'h2 && online_unit == 2'h1)
    |=> s_reg.rep[5] == 8'h42)
    else $error("Online unit byte wrong for a standby unit.");
  AST_PRIO_N: assert property (@(posedge sys_clk) disable iff (!rst_s_n)
    (is_chg && red_cfg == 2'h2 && f_pri == 8'h38) |=> chg_prio_stb)
    else $error("Priority eight refused in one-for-N.");

  // Main scenarios: an accepted change, a dropped frame, a raised interrupt.
  CVR_CHG: cover property (@(posedge sys_clk) disable iff (!rst_s_n)
    chg_online_stb);
  CVR_DROP: cover property (@(posedge sys_clk) disable iff (!rst_s_n)
    bus.frm_drop);
  CVR_IRQ: cover property (@(posedge sys_clk) disable iff (!rst_s_n) irq);
endmodule
`default_nettype wire

// [rrm_host.sv]
// Remote host model: frames requests onto the byte link and sinks replies.
// Assumes the handler's clock; the bench calls send and reads rep_q.
`timescale 1ns/10ps
`default_nettype none
module rrm_host (
  input  wire logic       clk,
  input  wire logic       slow,
  output logic      [7:0] rx_data,
  output logic            rx_valid,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  output logic            tx_ready
);
  logic [7:0] rep_q[$];
  logic       ph = 1'b0;
  // Idle link at time zero.
  initial
  begin
    rx_data  = 8'h00;
    rx_valid = 1'b0;
  end
  // Sink keeps each byte taken; when slow it stalls every other cycle.
  always @(posedge clk)
  begin
    if (tx_valid && tx_ready)
      rep_q.push_back(tx_data);
    ph       <= ~ph;
    tx_ready <= ~slow | ph;
  end
  // Sends one frame, the checksum optionally spoilt.
  task automatic send(input logic [7:0] adr, input logic [7:0] ins,
                      input logic [23:0] fld, input int nf, input logic bad);
    logic [7:0] by[$];
    logic [7:0] sum;
    by = {8'h02, 8'(nf + 6), adr, ins};
    for (int i = 0; i < nf; i++)
      by.push_back(fld[23 - 8 * i -: 8]);
    sum = 8'h00;
    foreach (by[i])
      if (i > 0)
        sum += by[i];
    by.push_back(sum ^ {7'h00, bad});
    by.push_back(8'h03);
    foreach (by[i])
    begin
      @(posedge clk);
      rx_data  <= by[i];
      rx_valid <= 1'b1;
    end
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_data  <= ~by[by.size() - 1];
  endtask
endmodule
`default_nettype wire

// [tb_rrm_top.sv]
// Self-checking bench for the redundancy message handler.
// Assumes rrm_top, rrm_host and the handler's package and interface.
`timescale 1ns/10ps
`default_nettype none
module tb_rrm_top;
  logic sys_clk, rst_n, reg_wr, reg_rd, irq, rx_valid, tx_valid, tx_ready;
  logic red_auto, unit_online, ctrl_present, coax_pos, slow;
  logic chg_mode_stb, chg_mode_auto, chg_online_stb, chg_prio_stb;
  logic [1:0]  red_cfg, unit_id, online_unit, chg_online_unit;
  logic [3:0]  reg_addr, unit_prio, chg_prio;
  logic [7:0]  rx_data, tx_data;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic [2:0]  seen;
  int          fails, tests_run, cyc, vcnt;

  rrm_top i_dut (.sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .irq, .rx_data, .rx_valid, .tx_data, .tx_valid, .tx_ready,
    .red_cfg, .red_auto, .unit_id, .unit_online, .unit_prio, .ctrl_present,
    .online_unit, .coax_pos, .chg_mode_stb, .chg_mode_auto, .chg_online_stb,
    .chg_online_unit, .chg_prio_stb, .chg_prio);
  rrm_host i_host (.clk(sys_clk), .slow, .rx_data, .rx_valid, .tx_data,
    .tx_valid, .tx_ready);

  // Clock at 5 ns period.
  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // Watches strobes and reply cycles, and cuts a hang short.
  always @(posedge sys_clk)
  begin
    cyc++;
    if (tx_valid === 1'b1) vcnt++;
    if (chg_mode_stb === 1'b1) seen[2] = 1'b1;
    if (chg_online_stb === 1'b1) seen[1] = 1'b1;
    if (chg_prio_stb === 1'b1) seen[0] = 1'b1;
    if (cyc == 20000)
    begin
      fails++;
      $display("mismatch at %0t: run did not finish", $time);
      wrap_up();
    end
  end

  task automatic wrap_up;
    $display("counts: %0d compares, %0d mismatches", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic reg_read(input logic [3:0] a, output logic [31:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1 v = reg_rdata;
  endtask

  task automatic irq_chk(input logic exp);
    repeat (2) @(posedge sys_clk);
    #1 check(32'(irq), 32'(exp), "irq level");
  endtask

  function automatic logic [7:0] idc(input logic [1:0] u);
    return (u == 2'h0) ? 8'h41 : (u == 2'h1) ? 8'h42 : 8'h53;
  endfunction

  // Sets the unit state, asks for status and compares the whole reply.
  task automatic stat_case(input logic [1:0] c, input logic au,
      input logic [1:0] id, input logic on, input logic [3:0] pr,
      input logic ct, input logic [1:0] ou, input logic cx, input logic sl);
    logic [7:0] e[13];
    @(posedge sys_clk);
    red_cfg <= c;
    red_auto <= au;
    unit_id <= id;
    unit_online <= on;
    unit_prio <= pr;
    ctrl_present <= ct;
    online_unit <= ou;
    coax_pos <= cx;
    slow <= sl;
    vcnt = 0;
    i_host.send(8'h01, 8'h45, 24'h0, 0, 1'b0);
    e = '{8'h02, 8'h0D, 8'h01, 8'h46,
          (c == 2'h0) ? 8'h31 : (c == 2'h1) ? 8'h32 : 8'h4E,
          (c == 2'h0) ? 8'h58 : au ? 8'h41 : 8'h4D,
          on ? 8'h31 : 8'h30, idc(id),
          (c == 2'h0 || id == 2'h2) ? 8'h58 : 8'h30 + {4'h0, pr},
          !ct ? 8'h40 : (c == 2'h0 || (c == 2'h1 && id == 2'h2)) ?
            idc(ou) : 8'h58,
          !ct ? 8'h40 : cx ? 8'h32 : 8'h31, 8'h00, 8'h03};
    for (int i = 1; i < 11; i++)
      e[11] += e[i];
    for (int n = 0; n < 200 && i_host.rep_q.size() < 13; n++)
      @(posedge sys_clk);
    repeat (8) @(posedge sys_clk);
    check(32'(i_host.rep_q.size()), 32'hD, "reply length");
    foreach (e[i])
      check(32'(i_host.rep_q[i]), 32'(e[i]), "reply byte");
    if (!sl)
      check(32'(vcnt), 32'hD, "reply cycles");
    i_host.rep_q.delete();
    $display("test status reply done");
  endtask

  // Sends a change request and compares strobes and accepted values.
  task automatic chg_case(input logic [1:0] c, input logic [1:0] id,
                          input logic [23:0] f, input logic [2:0] ex);
    @(posedge sys_clk);
    red_cfg <= c;
    unit_id <= id;
    seen = 3'h0;
    i_host.send(8'h01, 8'h47, f, 3, 1'b0);
    repeat (6) @(posedge sys_clk);
    check(32'(seen), 32'(ex), "change strobes");
    if (ex[2])
      check(32'(chg_mode_auto), 32'(f[23:16] == 8'h41), "mode");
    if (ex[1])
      check(32'(chg_online_unit), (f[15:8] == 8'h53) ? 32'h2 :
            32'(2'(f[9:8] - 2'h1)), "online unit");
    if (ex[0])
      check(32'(chg_prio), 32'(f[3:0]), "priority");
    $display("test change request done");
  endtask

  // Main sequence.
  initial
  begin
    fails = 0; tests_run = 0; cyc = 0; vcnt = 0; seen = 3'h0;
    rst_n = 1'b0; reg_addr = 4'h0; reg_wdata = 32'h0; reg_wr = 1'b0;
    reg_rd = 1'b0; red_cfg = 2'h0; red_auto = 1'b0; unit_id = 2'h0;
    unit_online = 1'b0; unit_prio = 4'h1; ctrl_present = 1'b0;
    online_unit = 2'h0; coax_pos = 1'b0; slow = 1'b0;
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    reg_read(4'h0, d);
    check(d, 32'h1, "own address reset");
    reg_read(4'h8, d);
    check(d, 32'h0, "mask reset");
    reg_read(4'h2, d);
    check(d, 32'h0, "unmapped read");
    reg_write(4'h8, 32'h1);
    $display("test registers done");
    stat_case(2'h0, 1'b0, 2'h0, 1'b1, 4'h1, 1'b1, 2'h0, 1'b0, 1'b0);
    irq_chk(1'b1);
    reg_read(4'h4, d);
    check(d, 32'h1, "reply sent status");
    reg_write(4'h4, 32'h1);
    irq_chk(1'b0);
    stat_case(2'h1, 1'b1, 2'h2, 1'b0, 4'h1, 1'b1, 2'h1, 1'b1, 1'b1);
    stat_case(2'h1, 1'b0, 2'h1, 1'b1, 4'h2, 1'b0, 2'h0, 1'b0, 1'b0);
    stat_case(2'h2, 1'b1, 2'h0, 1'b1, 4'h5, 1'b1, 2'h1, 1'b1, 1'b1);
    slow <= 1'b0;
    chg_case(2'h1, 2'h2, 24'h414231, 3'h6);
    chg_case(2'h1, 2'h0, 24'h4D5332, 3'h1);
    chg_case(2'h0, 2'h1, 24'h414132, 3'h2);
    chg_case(2'h1, 2'h1, 24'h4D4233, 3'h0);
    chg_case(2'h1, 2'h2, 24'h515A31, 3'h0);
    chg_case(2'h2, 2'h0, 24'h4D4139, 3'h4);
    chg_case(2'h2, 2'h0, 24'h415338, 3'h5);
    reg_read(4'hC, d);
    check(d, 32'h85, "last change info");
    reg_read(4'h4, d);
    check(d & 32'h2, 32'h2, "change status");
    reg_write(4'h4, 32'h7);
    i_host.send(8'h05, 8'h45, 24'h0, 0, 1'b0);
    i_host.send(8'h01, 8'h45, 24'h0, 0, 1'b1);
    repeat (40) @(posedge sys_clk);
    check(32'(i_host.rep_q.size()), 32'h0, "no reply to bad frames");
    reg_read(4'h4, d);
    check(d & 32'h4, 32'h4, "drop status");
    irq_chk(1'b0);
    reg_write(4'h8, 32'h4);
    irq_chk(1'b1);
    reg_write(4'h4, 32'h4);
    irq_chk(1'b0);
    $display("test drops and interrupt done");
    wrap_up();
  end
endmodule
`default_nettype wire
